// *** hdl/loop_det_consts.svh ***
`ifndef LOOP_DET_CONSTS_SVH
`define LOOP_DET_CONSTS_SVH
// clock and time base
`define LD_CLK_NS      5
`define LD_MS_NS       1000000
// times in ms
`define LD_HOLD_MS     3000
`define LD_BL_MS       900000
`define LD_OPER_MS     2000
`define LD_TUNE_MS     1000
`define LD_WARM_MS     30000
`define LD_RESP_MS     96
`define LD_FLASH_MS    (1000/6)
`define LD_DEB_MS      10
`define LD_PULSE_MS    250
// register byte offsets
`define LD_CTRL_OFS    8'h00
`define LD_STAT_OFS    8'h04
`define LD_VCNT_OFS    8'h08
`define LD_FCNT_OFS    8'h0c
`define LD_ISTA_OFS    8'h10
`define LD_IMSK_OFS    8'h14
// control fields
`define LD_POL_BIT     0
`define LD_MULTI_BIT   1
`define LD_PROG_BIT    2
`define LD_SENS_LO     3
`define LD_SENS_HI     6
`define LD_FREQ_LO     7
`define LD_FREQ_HI     9
`define LD_CLR_BIT     10
// reset values and limits
`define LD_SENS_RST    4'h6
`define LD_FREQ_RST    3'h0
`define LD_SENS_MAX    4'h9
`define LD_VCNT_MAX    17'h1869f
`define LD_IND_MIN     16'h0014
`define LD_IND_MAX     16'h09c4
`define LD_THR_MUL     7'h69
`define LD_THR_SH      5'h0b
// interrupt bits
`define LD_IRQ_FAULT   0
`define LD_IRQ_VEH     1
`define LD_IRQ_READY   2
`endif

// *** hdl/loop_det_pkg.sv ***
package loop_det_pkg;
  // detector life cycle, one-hot
  typedef enum logic [2:0] {
    ST_TUNE = 3'b001,
    ST_WARM = 3'b010,
    ST_RUN  = 3'b100
  } det_state_t;

  // one wishbone request as sampled
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic        we;
    logic        req;
  } wb_req_t;

  // status word layout
  typedef struct packed {
    logic       flash;
    logic       flt_high;
    logic       flt_low;
    logic       fault;
    logic       gate;
    logic       call;
    logic [2:0] state;
  } stat_t;
endpackage

// *** hdl/loop_detector_supervisor.sv ***
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "loop_det_consts.svh"
module loop_detector_supervisor #(
  parameter int unsigned MS_CYCLES = `LD_MS_NS / `LD_CLK_NS
) (
  input  wire logic        CLK_IN,       // 200 MHz clock
  input  wire logic        RST_B_IN,     // power-on reset, low
  input  wire logic        GATE_IN,      // gate control pin
  input  wire logic [2:0]  BTN_IN,       // buttons, bit 0 function
  input  wire logic [15:0] IND_IN,       // loop inductance sample
  input  wire logic        IND_VALID_IN, // sample strobe
  input  wire logic        WB_CYC_IN,    // wishbone cycle
  input  wire logic        WB_STB_IN,    // wishbone strobe
  input  wire logic        WB_WE_IN,     // wishbone write
  input  wire logic [7:0]  WB_ADR_IN,    // byte address
  input  wire logic [3:0]  WB_SEL_IN,    // byte lanes
  input  wire logic [31:0] WB_DAT_IN,    // write data
  output logic [31:0]      WB_DAT_OUT,   // read data
  output logic             WB_ACK_OUT,   // acknowledge
  output logic             CALL_OUT,     // call relay
  output logic             COUNT_OUT,    // count relay pulse
  output logic             LED_OUT,      // detect indicator
  output logic             BACKLIGHT_OUT,// display backlight
  output logic             FAULT_OUT,    // loop fail message
  output logic             FAULT_LOW_OUT,// fault_low_indication
  output logic             FAULT_HIGH_OUT,// fault_high_indication
  output logic             READY_OUT,    // tuned and operating
  output logic             IRQ_OUT       // interrupt level
);
  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);

  // ms time base shared by every timer
  logic [MS_W-1:0] ms_cnt_ff;
  wire             tick = (ms_cnt_ff == MS_W'(MS_CYCLES - 1));
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) ms_cnt_ff <= '0;
    else ms_cnt_ff <= tick ? '0 : ms_cnt_ff + 1'b1;
  end

  // three-stage sync, then stable for the debounce time
  wire  [3:0] raw = {BTN_IN, GATE_IN};
  logic [3:0] s1_ff, s2_ff, s3_ff, deb_ff;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_deb
    logic [3:0] dcnt_ff;
    wire        settle = (s2_ff[i] == s3_ff[i]) && (s3_ff[i] != deb_ff[i]);
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        dcnt_ff   <= '0;
        deb_ff[i] <= 1'b0;
      end else if (!settle) begin
        dcnt_ff <= '0;
      end else if (tick) begin
        if (dcnt_ff == 4'(`LD_DEB_MS - 1)) begin
          deb_ff[i] <= s3_ff[i];
          dcnt_ff   <= '0;
        end else begin
          dcnt_ff <= dcnt_ff + 1'b1;
        end
      end
    end
  end

  // register state
  logic        pol_ff, multi_ff, prog_ff;
  logic [3:0]  sens_ff;
  logic [2:0]  freq_ff;
  logic [2:0]  ista_ff, imsk_ff;
  logic [16:0] vcnt_ff;
  logic [15:0] fcnt_ff;

  // wishbone decode, writes land on the edge that sees ack
  loop_det_pkg::wb_req_t rq;
  assign rq = '{adr: WB_ADR_IN, dat: WB_DAT_IN, we: WB_WE_IN, req: WB_CYC_IN & WB_STB_IN};
  wire        wr     = rq.req & rq.we & WB_ACK_OUT & WB_SEL_IN[0];
  wire        wr_hi  = rq.req & rq.we & WB_ACK_OUT & WB_SEL_IN[1];
  wire        wr_ctl = wr & (rq.adr == `LD_CTRL_OFS);
  wire [3:0]  w_sens = rq.dat[`LD_SENS_HI:`LD_SENS_LO];
  wire [2:0]  w_freq = rq.dat[`LD_FREQ_HI:`LD_FREQ_LO];
  wire        sens_ok = (w_sens != 4'h0) && (w_sens <= `LD_SENS_MAX);
  wire        sens_wr = wr_ctl & wr_hi & sens_ok;
  wire        freq_wr = wr_ctl & wr_hi;
  wire        set_chg = (sens_wr & (w_sens != sens_ff)) | (freq_wr & (w_freq != freq_ff));
  wire        cnt_clr = wr_ctl & wr_hi & rq.dat[`LD_CLR_BIT];
  wire        ista_wr = wr & (rq.adr == `LD_ISTA_OFS);
  wire        imsk_wr = wr & (rq.adr == `LD_IMSK_OFS);

  // control register; illegal sensitivity codes are ignored
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pol_ff   <= 1'b0;
      multi_ff <= 1'b0;
      prog_ff  <= 1'b0;
      sens_ff  <= `LD_SENS_RST;
      freq_ff  <= `LD_FREQ_RST;
      imsk_ff  <= '0;
    end else begin
      if (wr_ctl) begin
        pol_ff   <= rq.dat[`LD_POL_BIT];
        multi_ff <= rq.dat[`LD_MULTI_BIT];
        prog_ff  <= rq.dat[`LD_PROG_BIT];
      end
      if (sens_wr) sens_ff <= w_sens;
      if (freq_wr) freq_ff <= w_freq;
      if (imsk_wr) imsk_ff <= rq.dat[2:0];
    end
  end

  // gate polarity and button edges
  wire       gate_act = deb_ff[0] ^ pol_ff;
  logic [2:0] btn_prev_ff;
  wire  [2:0] press = deb_ff[3:1] & ~btn_prev_ff;
  wire        function_button_held = deb_ff[1] & ~prog_ff;

  // function button hold timer fires one manual reset per hold
  logic [11:0] hold_ff;
  logic        hold_done_ff;
  wire         man_rst = function_button_held & ~hold_done_ff & tick & (hold_ff == 12'(`LD_HOLD_MS - 1));
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      btn_prev_ff  <= '0;
      hold_ff      <= '0;
      hold_done_ff <= 1'b0;
    end else begin
      btn_prev_ff <= deb_ff[3:1];
      if (!function_button_held) begin
        hold_ff      <= '0;
        hold_done_ff <= 1'b0;
      end else if (man_rst) begin
        hold_done_ff <= 1'b1;
      end else if (tick && !hold_done_ff) begin
        hold_ff <= hold_ff + 1'b1;
      end
    end
  end
  wire det_rst = man_rst | set_chg;

  // backlight from any press, 15 minute idle timeout
  logic [19:0] bl_ff;
  wire         any_press = |press;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bl_ff         <= '0;
      BACKLIGHT_OUT <= 1'b0;
    end else begin
      if (any_press) bl_ff <= 20'(`LD_BL_MS);
      else if (tick && bl_ff != '0) bl_ff <= bl_ff - 1'b1;
      BACKLIGHT_OUT <= any_press | (bl_ff != '0);
    end
  end

  // latest inductance sample
  logic [15:0] ind_ff, ref_ff;
  logic        meas_ff, ref_ok_ff;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ind_ff  <= '0;
      meas_ff <= 1'b0;
    end else if (IND_VALID_IN) begin
      ind_ff  <= IND_IN;
      meas_ff <= 1'b1;
    end
  end

  // tune, warm-up, run; reference taken during tuning
  loop_det_pkg::det_state_t st_ff;
  logic [14:0] st_tmr_ff;
  wire         tune_end = tick && st_tmr_ff >= 15'(`LD_TUNE_MS - 1) && ref_ok_ff;
  wire         warm_end = tick && st_tmr_ff == 15'(`LD_WARM_MS - 1);
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_ff     <= loop_det_pkg::ST_TUNE;
      st_tmr_ff <= '0;
      ref_ff    <= '0;
      ref_ok_ff <= 1'b0;
    end else if (det_rst) begin
      st_ff     <= loop_det_pkg::ST_TUNE;
      st_tmr_ff <= '0;
      ref_ok_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        loop_det_pkg::ST_TUNE: begin
          if (IND_VALID_IN) begin
            ref_ff    <= IND_IN;
            ref_ok_ff <= 1'b1;
          end
          if (tune_end) begin
            st_ff     <= loop_det_pkg::ST_WARM;
            st_tmr_ff <= '0;
          end else if (tick && st_tmr_ff < 15'(`LD_OPER_MS)) begin
            st_tmr_ff <= st_tmr_ff + 1'b1;
          end
        end
        loop_det_pkg::ST_WARM: begin
          if (warm_end) st_ff <= loop_det_pkg::ST_RUN;
          if (tick) st_tmr_ff <= st_tmr_ff + 1'b1;
        end
        loop_det_pkg::ST_RUN: st_tmr_ff <= '0;
        default: st_ff <= loop_det_pkg::ST_TUNE;
      endcase
    end
  end
  wire operating = ~st_ff[0];

  // loop fault: range always, +-25% once a reference exists
  wire [15:0] quarter  = {2'b00, ref_ff[15:2]};
  wire        flt_low  = meas_ff & ((ind_ff < `LD_IND_MIN) | (ref_ok_ff & (ind_ff < ref_ff - quarter)));
  wire        flt_high = meas_ff & ((ind_ff > `LD_IND_MAX) |
                         (ref_ok_ff & ({1'b0, ind_ff} > {1'b0, ref_ff} + {1'b0, quarter})));
  wire        fault    = flt_low | flt_high;
  logic       fault_q_ff;
  wire        fault_rise = fault & ~fault_q_ff;

  // threshold: 2.56% of reference, halved per level, coarser in warm-up
  wire [22:0] thr_full = ref_ff * `LD_THR_MUL;
  wire [4:0]  thr_sh   = `LD_THR_SH + {1'b0, sens_ff} - {4'h0, st_ff[1]};
  wire [22:0] thr      = thr_full >> thr_sh;
  wire [15:0] delta    = ref_ff - ind_ff;
  wire        present  = operating & ~fault & (ind_ff < ref_ff) & ({7'h00, delta} > thr);

  // presence must hold the response time before a call
  logic [6:0] resp_ff;
  logic       det_ff;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      resp_ff <= '0;
      det_ff  <= 1'b0;
    end else if (!present || det_rst) begin
      resp_ff <= '0;
      det_ff  <= 1'b0;
    end else if (tick) begin
      if (resp_ff == 7'(`LD_RESP_MS - 1)) det_ff <= 1'b1;
      else resp_ff <= resp_ff + 1'b1;
    end
  end

  // vehicle counting; first entry skipped while gate open in multi mode
  logic det_q_ff, first_ff;
  wire  vehicle = det_ff & ~det_q_ff;
  wire  skip    = multi_ff & gate_act & first_ff;
  wire  inc     = vehicle & ~skip;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      det_q_ff <= 1'b0;
      first_ff <= 1'b1;
      vcnt_ff  <= '0;
    end else begin
      det_q_ff <= det_ff;
      if (!gate_act) first_ff <= 1'b1;
      else if (vehicle && multi_ff) first_ff <= 1'b0;
      if (cnt_clr) vcnt_ff <= '0;
      else if (inc) vcnt_ff <= (vcnt_ff == `LD_VCNT_MAX) ? '0 : vcnt_ff + 1'b1;
    end
  end

  // count relay pulse
  logic [7:0] pulse_ff;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pulse_ff  <= '0;
      COUNT_OUT <= 1'b0;
    end else begin
      if (inc) pulse_ff <= 8'(`LD_PULSE_MS);
      else if (tick && pulse_ff != '0) pulse_ff <= pulse_ff - 1'b1;
      COUNT_OUT <= inc | (pulse_ff != '0);
    end
  end

  // fault memory and latched flash; only manual or power reset clears
  logic       flash_ff, ph_ff;
  logic [7:0] ph_tmr_ff;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      fault_q_ff <= 1'b0;
      fcnt_ff    <= '0;
      flash_ff   <= 1'b0;
      ph_ff      <= 1'b0;
      ph_tmr_ff  <= '0;
    end else begin
      fault_q_ff <= fault;
      if (man_rst) fcnt_ff <= '0;
      else if (fault_rise) fcnt_ff <= fcnt_ff + 1'b1;
      if (fault_rise) flash_ff <= 1'b1;
      else if (man_rst) flash_ff <= 1'b0;
      if (tick) begin
        ph_tmr_ff <= (ph_tmr_ff == 8'(`LD_FLASH_MS - 1)) ? '0 : ph_tmr_ff + 1'b1;
        if (ph_tmr_ff == 8'(`LD_FLASH_MS - 1)) ph_ff <= ~ph_ff;
      end
    end
  end

  // outputs; fail-safe forces a call, message tracks live fault
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CALL_OUT       <= 1'b0;
      LED_OUT        <= 1'b0;
      FAULT_OUT      <= 1'b0;
      FAULT_LOW_OUT  <= 1'b0;
      FAULT_HIGH_OUT <= 1'b0;
      READY_OUT      <= 1'b0;
    end else begin
      CALL_OUT       <= det_ff | fault;
      LED_OUT        <= flash_ff ? ph_ff : (det_ff | fault);
      FAULT_OUT      <= fault;
      FAULT_LOW_OUT  <= flt_low;
      FAULT_HIGH_OUT <= flt_high & ~flt_low;
      READY_OUT      <= operating;
    end
  end

  // sticky interrupt status, set wins over write-one-clear
  wire [2:0] ev = {operating & ~READY_OUT, inc, fault_rise};
  wire [2:0] w1c = ista_wr ? rq.dat[2:0] : 3'h0;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ista_ff <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      ista_ff <= (ista_ff & ~w1c) | ev;
      IRQ_OUT <= |(((ista_ff & ~w1c) | ev) & imsk_ff);
    end
  end

  // read mux; fault count visible only in programming mode
  loop_det_pkg::stat_t stat;
  assign stat = '{flash: flash_ff, flt_high: FAULT_HIGH_OUT, flt_low: FAULT_LOW_OUT,
                  fault: FAULT_OUT, gate: gate_act, call: CALL_OUT, state: st_ff};
  wire [31:0] ctrl_rd = {22'h0, freq_ff, sens_ff, prog_ff, multi_ff, pol_ff};
  wire [31:0] rd = (rq.adr == `LD_CTRL_OFS) ? ctrl_rd :
                   (rq.adr == `LD_STAT_OFS) ? {23'h0, stat} :
                   (rq.adr == `LD_VCNT_OFS) ? {15'h0, vcnt_ff} :
                   (rq.adr == `LD_FCNT_OFS) ? (prog_ff ? {16'h0, fcnt_ff} : 32'h0) :
                   (rq.adr == `LD_ISTA_OFS) ? {29'h0, ista_ff} :
                   (rq.adr == `LD_IMSK_OFS) ? {29'h0, imsk_ff} : 32'h0;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= '0;
    end else begin
      WB_ACK_OUT <= rq.req & ~WB_ACK_OUT;
      if (rq.req && !WB_ACK_OUT) WB_DAT_OUT <= rd;
    end
  end

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  pol_map_a: assert property ($rose(deb_ff[0]) && !pol_ff && !wr_ctl |-> gate_act)
    else $error("gate polarity wrong");
  hold_rst_a: assert property (man_rst && !fault_rise |=> st_ff[0] && fcnt_ff == '0 && !flash_ff)
    else $error("manual reset incomplete");
  chg_tune_a: assert property (set_chg |=> st_ff == loop_det_pkg::ST_TUNE)
    else $error("setting change did not retune");
  keep_cnt_a: assert property (det_rst && !cnt_clr && !inc |=> vcnt_ff == $past(vcnt_ff))
    else $error("reset altered vehicle count");
  bl_on_a: assert property (any_press |=> ##1 BACKLIGHT_OUT)
    else $error("backlight not lit by press");
  tune_bnd_a: assert property (st_ff == loop_det_pkg::ST_TUNE |-> st_tmr_ff <= 15'(`LD_OPER_MS))
    else $error("tuning timer overran");
  fail_call_a: assert property (fault |=> CALL_OUT && FAULT_OUT)
    else $error("fault without fail-safe call");
  flash_hold_a: assert property (flash_ff && !man_rst |=> flash_ff)
    else $error("flash latch dropped");
  fcnt_inc_a: assert property (fault_rise && !man_rst |=> fcnt_ff == $past(fcnt_ff) + 16'h1)
    else $error("fault count missed");
  wrap_a: assert property (inc && !cnt_clr && vcnt_ff == `LD_VCNT_MAX |=> vcnt_ff == '0)
    else $error("vehicle count no rollover");
  skip_first_a: assert property (vehicle & skip & ~cnt_clr |=> $stable(vcnt_ff) && pulse_ff != 8'(`LD_PULSE_MS))
    else $error("first entry counted");
  fault_cv: cover property (fault_rise ##[1:300] !fault);
  veh_cv: cover property (inc ##1 COUNT_OUT);
  hold_cv: cover property (man_rst ##1 st_ff == loop_det_pkg::ST_TUNE);
endmodule

// *** verif/loop_model.sv ***
`timescale 1ns/10ps
// loop oscillator stand-in: one inductance sample every eight cycles
module loop_model (
  input  wire logic        clk_in,   // system clock
  input  wire logic        rst_b_in, // reset, low
  input  wire logic [15:0] ind_in,   // inductance the loop shows now
  output logic [15:0]      ind_out,  // sample bus
  output logic             valid_out // sample strobe
);
  logic [2:0]  div_ff;
  logic [15:0] last_ff;
  // off the strobe the bus carries the inverse, so a stale sample never looks valid
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_ff    <= 3'h0;
      valid_out <= 1'b0;
      last_ff   <= 16'h0000;
      ind_out   <= 16'hffff;
    end else begin
      div_ff    <= div_ff + 3'h1;
      valid_out <= (div_ff == 3'h7);
      if (div_ff == 3'h7) begin
        last_ff <= ind_in;
        ind_out <= ind_in;
      end else begin
        ind_out <= ~last_ff;
      end
    end
  end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin n_errors++; $display("mismatch %0t %s", $time, m); end end
`define WAITF(c, n) for (w = 0; w < (n) && !(c); w++) @(posedge clk);
module tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, gate = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [2:0]  btn = 3'h0;
  logic [15:0] ind_tgt = 16'h03e8;
  logic [15:0] ind;
  logic        ind_vld, ack, call, cnt_pulse, led, bl, flt, flt_lo, flt_hi, ready, irq, lv;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, d, v0;
  int          n_errors = 0, cmp_count = 0, cyc_cnt = 0, t_ready = 0, w;

  always #2.5 clk = ~clk;

  // one tick per cycle keeps the long timers inside the run budget
  loop_detector_supervisor #(.MS_CYCLES(1)) uut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .GATE_IN(gate), .BTN_IN(btn), .IND_IN(ind), .IND_VALID_IN(ind_vld),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CALL_OUT(call), .COUNT_OUT(cnt_pulse), .LED_OUT(led),
    .BACKLIGHT_OUT(bl), .FAULT_OUT(flt), .FAULT_LOW_OUT(flt_lo), .FAULT_HIGH_OUT(flt_hi),
    .READY_OUT(ready), .IRQ_OUT(irq));

  loop_model lm (.clk_in(clk), .rst_b_in(rst_b), .ind_in(ind_tgt), .ind_out(ind), .valid_out(ind_vld));

  task final_report;
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the sequence needs about 40300 cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 50000) begin
      n_errors++;
      final_report;
    end
  end

  // classic single wishbone cycle; read data lands in d
  task wb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; wdat <= dt; sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    `CHK(ack, 1'b1, "no acknowledge")
    d = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task t_reset;
    `CHK({call, cnt_pulse, led, bl, flt, ready, irq}, 7'h00, "outputs after reset")
    wb(1'b0, 8'h00, 32'h0); `CHK(d, 32'h00000030, "control reset value")
    wb(1'b0, 8'h14, 32'h0); `CHK(d, 32'h0, "mask reset value")
    wb(1'b0, 8'h20, 32'h0); `CHK(d, 32'h0, "unmapped read")
    wb(1'b0, 8'h08, 32'h0); `CHK(d, 32'h0, "vehicle count reset")
  endtask

  task t_tune;
    `WAITF(ready === 1'b1, 2100)
    `CHK(ready, 1'b1, "not operational in time")
    t_ready = cyc_cnt;
    wb(1'b0, 8'h04, 32'h0); `CHK(d[2:0], 3'h2, "not in warm-up")
    wb(1'b0, 8'h10, 32'h0); `CHK(d[2], 1'b1, "ready event missing")
    `CHK(irq, 1'b0, "interrupt while masked")
    wb(1'b1, 8'h14, 32'h4); repeat (3) @(posedge clk);
    `CHK(irq, 1'b1, "interrupt not raised")
    wb(1'b1, 8'h10, 32'h4); repeat (3) @(posedge clk);
    `CHK(irq, 1'b0, "interrupt not cleared")
    wb(1'b1, 8'h14, 32'h0);
  endtask

  task t_gate;
    gate <= 1'b1;
    wb(1'b0, 8'h04, 32'h0); `CHK(d[4], 1'b0, "gate seen before debounce")
    repeat (30) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0); `CHK(d[4], 1'b1, "high gate not active")
    wb(1'b1, 8'h00, 32'h31); repeat (5) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0); `CHK(d[4], 1'b0, "inverted high gate active")
    gate <= 1'b0; repeat (30) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0); `CHK(d[4], 1'b1, "inverted low gate inactive")
    wb(1'b1, 8'h00, 32'h30);
  endtask

  task pass_vehicle(input logic pulse_exp);
    ind_tgt <= 16'h0384;
    `WAITF(call === 1'b1, 200)
    `CHK(cnt_pulse, pulse_exp, "count pulse wrong")
    ind_tgt <= 16'h03e8;
    `WAITF(call === 1'b0, 60)
    repeat (300) @(posedge clk);
  endtask

  task t_vehicle;
    ind_tgt <= 16'h0384; repeat (70) @(posedge clk);
    `CHK(call, 1'b0, "call before response time")
    `WAITF(call === 1'b1, 60)
    `CHK(call, 1'b1, "no call within response time")
    `CHK(cnt_pulse, 1'b1, "no count pulse")
    @(posedge clk); `CHK(led, 1'b1, "led not showing call")
    ind_tgt <= 16'h03e8;
    `WAITF(call === 1'b0, 60)
    repeat (300) @(posedge clk);
    `CHK(cnt_pulse, 1'b0, "count pulse stuck")
    wb(1'b0, 8'h08, 32'h0); `CHK(d, 32'h1, "vehicle not counted")
  endtask

  task t_multi;
    wb(1'b1, 8'h00, 32'h32); gate <= 1'b1; repeat (30) @(posedge clk);
    wb(1'b0, 8'h08, 32'h0); v0 = d;
    pass_vehicle(1'b0);
    pass_vehicle(1'b1);
    wb(1'b0, 8'h08, 32'h0); `CHK(d, v0 + 32'h1, "first gated vehicle counted")
    gate <= 1'b0;
    wb(1'b1, 8'h00, 32'h30);
  endtask

  task t_fault;
    ind_tgt <= 16'h0514; repeat (20) @(posedge clk);
    `CHK({flt, flt_hi, flt_lo, call}, 4'hd, "rise fault not shown")
    repeat (100) @(posedge clk);
    `CHK({flt, flt_hi}, 2'h3, "fault dropped early")
    wb(1'b0, 8'h10, 32'h0); `CHK(d[0], 1'b1, "fault event missing")
    ind_tgt <= 16'h03e8; repeat (20) @(posedge clk);
    `CHK({flt, call}, 2'h0, "healed fault still shown")
    wb(1'b0, 8'h04, 32'h0); `CHK(d[8], 1'b1, "flash not latched")
    ind_tgt <= 16'h000a; repeat (20) @(posedge clk);
    `CHK({flt, flt_hi, flt_lo}, 3'h5, "low fault type")
    ind_tgt <= 16'h03e8; repeat (20) @(posedge clk);
    lv = led;
    `WAITF(led !== lv, 180)
    `CHK(led, ~lv, "led not flashing")
    lv = led; repeat (150) @(posedge clk);
    `CHK(led, lv, "flash faster than three per second")
    wb(1'b0, 8'h0c, 32'h0); `CHK(d, 32'h0, "fault count outside programming")
    wb(1'b1, 8'h00, 32'h34);
    wb(1'b0, 8'h0c, 32'h0); `CHK(d, 32'h2, "fault count")
    wb(1'b1, 8'h00, 32'h30);
  endtask

  task t_warm;
    `WAITF(cyc_cnt >= t_ready + 29900, 40000)
    wb(1'b0, 8'h04, 32'h0); `CHK(d[2:0], 3'h2, "warm-up ended early")
    `WAITF(cyc_cnt >= t_ready + 30200, 400)
    wb(1'b0, 8'h04, 32'h0); `CHK(d[2:0], 3'h4, "warm-up too long")
  endtask

  task t_sens;
    wb(1'b0, 8'h08, 32'h0); v0 = d;
    wb(1'b1, 8'h00, 32'h28);
    `WAITF(ready === 1'b0, 5)
    `CHK(ready, 1'b0, "sensitivity change no reset")
    `WAITF(ready === 1'b1, 2100)
    `CHK(ready, 1'b1, "retune too slow")
    wb(1'b1, 8'h00, 32'ha8);
    `WAITF(ready === 1'b0, 5)
    `CHK(ready, 1'b0, "frequency change no reset")
    wb(1'b0, 8'h08, 32'h0); `CHK(d, v0, "count lost on setting change")
    wb(1'b0, 8'h04, 32'h0); `CHK(d[8], 1'b1, "flash lost on setting change")
    `WAITF(ready === 1'b1, 2100)
  endtask

  task t_button;
    `CHK(bl, 1'b0, "backlight on without press")
    btn <= 3'h1; repeat (20) @(posedge clk);
    `CHK(bl, 1'b1, "backlight off after press")
    repeat (2900) @(posedge clk);
    `CHK(ready, 1'b1, "button reset too soon")
    `WAITF(ready === 1'b0, 200)
    `CHK(ready, 1'b0, "button hold no reset")
    btn <= 3'h0;
    wb(1'b0, 8'h08, 32'h0); `CHK(d, v0, "count lost on button reset")
    wb(1'b0, 8'h04, 32'h0); `CHK(d[8], 1'b0, "flash kept after manual reset")
    wb(1'b1, 8'h00, 32'h2c);
    wb(1'b0, 8'h0c, 32'h0); `CHK(d, 32'h0, "fault count kept")
    wb(1'b1, 8'h00, 32'h42c);
    wb(1'b0, 8'h08, 32'h0); `CHK(d, 32'h0, "count clear bit ignored")
    `WAITF(ready === 1'b1, 2100)
    btn <= 3'h1; repeat (3100) @(posedge clk);
    `CHK(ready, 1'b1, "button reset in programming mode")
    btn <= 3'h0;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_tune;
    t_gate;
    t_vehicle;
    t_multi;
    t_fault;
    t_warm;
    t_sens;
    t_button;
    final_report;
  end
endmodule
